//--- rtl/hcp_pkg.sv
// Constants for the host control port: external map, fields, resets.
// Assumes a single 200 MHz core clock; all pins are asynchronous to it.
package hcp_pkg;
    localparam int          EXT_AW        = 3;
    localparam int          INT_AW        = 10;
    localparam int          INT_DW        = 20;
    localparam logic [2:0]  EXT_DATA_LOW  = 3'h0;
    localparam logic [2:0]  EXT_DATA_MID  = 3'h1;
    localparam logic [2:0]  EXT_DATA_HIGH = 3'h2;
    localparam logic [2:0]  EXT_SLEEP     = 3'h3;
    localparam logic [2:0]  EXT_PIN_SYNC  = 3'h4;
    localparam logic [2:0]  EXT_SOFT_SYNC = 3'h5;
    localparam logic [2:0]  EXT_CHAN_ADDR = 3'h6;
    localparam logic [2:0]  EXT_ADDR_CTRL = 3'h7;
    localparam int          NIBBLE_W      = 4;
    localparam int          ACR_HI_MSB    = 1;
    localparam int          ACR_AUTOINC   = 7;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [3:0]  SER_IDLE      = 4'h0;
    localparam logic [3:0]  SER_FRAME     = 4'h1;
    localparam logic [3:0]  SER_SHIFT0    = 4'h5;
    localparam logic [3:0]  SER_LAST      = 4'hf;
    localparam int          SER_BITS      = 11;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ACCESS = 4'b0010,
        ST_WAIT   = 4'b0100,
        ST_DONE   = 4'b1000
    } hcp_state_t;
endpackage : hcp_pkg

//--- rtl/hcp_serial_rx.sv
// Self-framing serial write receiver, slave only.
// Expects serial clock and data already passed through two flip-flops.
module hcp_serial_rx
    import hcp_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             sclk_sync,
    input  wire logic             sdi_sync,
    output logic                  ser_done,
    output logic [EXT_AW-1:0]     ser_addr,
    output logic [7:0]            ser_data
);
    logic                 sclk_prev;
    logic [3:0]           cnt;
    logic [SER_BITS-1:0]  shreg;
    logic                 next_done;
    logic [3:0]           next_cnt;
    logic [SER_BITS-1:0]  next_shreg;
    logic                 fall;

    // Only falling edges sample; no output is ever switched by this port
    assign fall = sclk_prev & ~sclk_sync;

    always_comb begin
        next_cnt   = cnt;
        next_shreg = shreg;
        next_done  = 1'b0;
        if (fall) begin
            if (cnt == SER_IDLE) begin
                if (sdi_sync) begin
                    next_cnt = SER_FRAME;
                end
            end else if (cnt < SER_SHIFT0) begin
                next_cnt = cnt + 4'h1;
            end else begin
                // Address then data, each MSB first
                next_shreg = {shreg[SER_BITS-2:0], sdi_sync};
                if (cnt == SER_LAST) begin
                    next_cnt  = SER_IDLE;
                    next_done = 1'b1;
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_prev <= 1'b0;
            cnt       <= SER_IDLE;
            shreg     <= '0;
            ser_done  <= 1'b0;
        end else begin
            sclk_prev <= sclk_sync;
            cnt       <= next_cnt;
            shreg     <= next_shreg;
            ser_done  <= next_done;
        end
    end

    assign ser_addr = shreg[SER_BITS-1:8];
    assign ser_data = shreg[7:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_no_reframe;
        (cnt != SER_IDLE) && fall |=> (cnt != SER_FRAME);
    endproperty
    a_no_reframe: assert property (p_no_reframe)
        else $error("frame detector re-armed mid frame");

    property p_frame_start;
        (cnt == SER_IDLE) && fall && sdi_sync |=> (cnt == SER_FRAME);
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame bit did not start the counter");
endmodule : hcp_serial_rx

//--- rtl/hcp_port.sv
// Host control port: 8-bit parallel port with two strobe conventions
// plus a serial write input that pre-empts it in ST_ACCESS only.
// Pins are asynchronous; internal register file answers in the same clock as the read pulse.
// Functional notes
// - Split mode: ready low until access completes
// - Strobe mode: ack low on completion, high after strobe
// - Serial reaches all registers, wins arbitration in ST_ACCESS only
// - Frame bit starts counter, skip four, shift
// - Serial address and data forwarded as write
// - Frame, don't-cares, address MSB, data MSB
// - Serial port is slave, clock external
// - Sample on falling serial clock edges
// - Low byte write copies all bytes inside
// - Low byte read loads higher bytes
// - High nibble register keeps four bits
// - Auto-increment channel address after low byte
// - Address 6 holds lower internal address
module hcp_port
    import hcp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               strobe_dir_mode,
    input  wire logic               cs_n,
    input  wire logic               rd_ds_n,
    input  wire logic               wr_rw_n,
    input  wire logic [EXT_AW-1:0]  host_addr,
    input  wire logic [7:0]         host_data_in,
    output logic      [7:0]         host_data_out,
    output logic                    host_data_oe,
    output logic                    transfer_ack_n,
    input  wire logic               serial_clk,
    input  wire logic               serial_ctrl_in,
    output logic      [INT_AW-1:0]  int_addr,
    output logic      [INT_DW-1:0]  int_wdata,
    output logic                    int_we,
    output logic                    int_re,
    input  wire logic [INT_DW-1:0]  int_rdata,
    output logic      [7:0]         sleep_ctrl,
    output logic      [7:0]         pin_sync_ctrl,
    output logic      [7:0]         soft_sync_ctrl
);
    localparam int PW = 6 + EXT_AW + 8;

    logic [PW-1:0]        pin_s1;
    logic [PW-1:0]        pin_s2;
    logic                 mode_s;
    logic                 cs_s;
    logic                 rd_s;
    logic                 wr_s;
    logic                 sclk_s;
    logic                 sdi_s;
    logic [EXT_AW-1:0]    addr_s;
    logic [7:0]           din_s;
    logic                 strobe_on;
    logic                 read_now;
    logic                 ser_done;
    logic [EXT_AW-1:0]    ser_addr;
    logic [7:0]           ser_data;

    hcp_state_t           state;
    hcp_state_t           next_state;
    logic                 acc_read;
    logic                 next_acc_read;
    logic [EXT_AW-1:0]    acc_addr;
    logic [EXT_AW-1:0]    next_acc_addr;
    logic [7:0]           acc_data;
    logic [7:0]           next_acc_data;
    logic [7:0]           data_low;
    logic [7:0]           next_data_low;
    logic [7:0]           data_mid;
    logic [7:0]           next_data_mid;
    logic [7:0]           data_high;
    logic [7:0]           next_data_high;
    logic [7:0]           chan_addr;
    logic [7:0]           next_chan_addr;
    logic [7:0]           addr_ctrl;
    logic [7:0]           next_addr_ctrl;
    logic [7:0]           next_sleep;
    logic [7:0]           next_pin_sync;
    logic [7:0]           next_soft_sync;
    logic [7:0]           next_dout;
    logic                 next_oe;
    logic [INT_AW-1:0]    next_int_addr;
    logic [INT_DW-1:0]    next_int_wdata;
    logic                 next_int_we;
    logic                 next_int_re;
    logic                 par_go;
    logic                 wr_go;
    logic [EXT_AW-1:0]    wr_a;
    logic [7:0]           wr_d;
    logic [INT_AW-1:0]    cur_int_addr;

    // Every pin, serial clock included, crosses through two flip-flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1 <= {3'h7, 3'h0, {(EXT_AW + 8){1'b0}}};
            pin_s2 <= {3'h7, 3'h0, {(EXT_AW + 8){1'b0}}};
        end else begin
            pin_s1 <= {cs_n, rd_ds_n, wr_rw_n, strobe_dir_mode, serial_clk,
                       serial_ctrl_in, host_addr, host_data_in};
            pin_s2 <= pin_s1;
        end
    end

    assign {cs_s, rd_s, wr_s, mode_s, sclk_s, sdi_s, addr_s, din_s} = pin_s2;

    // Split strobes when mode low, data strobe plus direction when high
    assign strobe_on = mode_s ? (~cs_s & ~rd_s)
                              : (~cs_s & (~rd_s | ~wr_s));
    assign read_now  = mode_s ? wr_s : ~rd_s;

    // Serial clock is only ever an input: this end never drives it
    hcp_serial_rx u_serial (
        .clk       (clk),
        .reset     (reset),
        .sclk_sync (sclk_s),
        .sdi_sync  (sdi_s),
        .ser_done  (ser_done),
        .ser_addr  (ser_addr),
        .ser_data  (ser_data)
    );

    assign cur_int_addr = {addr_ctrl[ACR_HI_MSB:0], chan_addr};

    always_comb begin
        next_state     = state;
        next_acc_read  = acc_read;
        next_acc_addr  = acc_addr;
        next_acc_data  = acc_data;
        next_data_low  = data_low;
        next_data_mid  = data_mid;
        next_data_high = data_high;
        next_chan_addr = chan_addr;
        next_addr_ctrl = addr_ctrl;
        next_sleep     = sleep_ctrl;
        next_pin_sync  = pin_sync_ctrl;
        next_soft_sync = soft_sync_ctrl;
        next_dout      = host_data_out;
        next_oe        = strobe_on & read_now;
        next_int_addr  = int_addr;
        next_int_wdata = int_wdata;
        next_int_we    = 1'b0;
        next_int_re    = 1'b0;
        // A finishing serial frame stalls ST_ACCESS this cycle; a ST_WAIT read load still overrides it
        par_go = (state == ST_ACCESS) && !ser_done;
        wr_go  = ser_done | (par_go & ~acc_read);
        wr_a   = ser_done ? ser_addr : acc_addr;
        wr_d   = ser_done ? ser_data : acc_data;
        if (wr_go) begin
            case (wr_a)
                EXT_DATA_LOW: begin
                    next_data_low  = wr_d;
                    next_int_addr  = cur_int_addr;
                    next_int_wdata = {data_high[NIBBLE_W-1:0], data_mid,
                                      wr_d};
                    next_int_we    = 1'b1;
                    if (addr_ctrl[ACR_AUTOINC]) begin
                        next_chan_addr = chan_addr + 8'h01;
                    end
                end
                EXT_DATA_MID:  next_data_mid = wr_d;
                EXT_DATA_HIGH: next_data_high = {4'h0,
                                   wr_d[NIBBLE_W-1:0]};
                EXT_SLEEP:     next_sleep = wr_d;
                EXT_PIN_SYNC:  next_pin_sync = wr_d;
                EXT_SOFT_SYNC: next_soft_sync = wr_d;
                EXT_CHAN_ADDR: next_chan_addr = wr_d;
                EXT_ADDR_CTRL: next_addr_ctrl = wr_d;
                default:       next_addr_ctrl = addr_ctrl;
            endcase
        end
        case (state)
            ST_IDLE: begin
                if (strobe_on) begin
                    next_state    = ST_ACCESS;
                    next_acc_read = read_now;
                    next_acc_addr = addr_s;
                    next_acc_data = din_s;
                end
            end
            ST_ACCESS: begin
                if (par_go && !acc_read) begin
                    next_state = ST_DONE;
                end else if (par_go && acc_addr == EXT_DATA_LOW) begin
                    next_int_addr = cur_int_addr;
                    next_int_re   = 1'b1;
                    next_state    = ST_WAIT;
                    if (addr_ctrl[ACR_AUTOINC]) begin
                        next_chan_addr = chan_addr + 8'h01;
                    end
                end else if (par_go) begin
                    next_state = ST_DONE;
                    case (acc_addr)
                        EXT_DATA_MID:  next_dout = data_mid;
                        EXT_DATA_HIGH: next_dout = data_high;
                        EXT_SLEEP:     next_dout = sleep_ctrl;
                        EXT_CHAN_ADDR: next_dout = chan_addr;
                        EXT_ADDR_CTRL: next_dout = addr_ctrl;
                        default:       next_dout = 8'h00;
                    endcase
                end
            end
            ST_WAIT: begin
                // Internal storage answers in the same clock as the read pulse
                next_data_low  = int_rdata[7:0];
                next_data_mid  = int_rdata[15:8];
                next_data_high = {4'h0, int_rdata[INT_DW-1:16]};
                next_dout      = int_rdata[7:0];
                next_state     = ST_DONE;
            end
            ST_DONE: begin
                if (!strobe_on) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state          <= ST_IDLE;
            acc_read       <= 1'b0;
            acc_addr       <= '0;
            acc_data       <= REG_RESET;
            data_low       <= REG_RESET;
            data_mid       <= REG_RESET;
            data_high      <= REG_RESET;
            chan_addr      <= REG_RESET;
            addr_ctrl      <= REG_RESET;
            sleep_ctrl     <= REG_RESET;
            pin_sync_ctrl  <= REG_RESET;
            soft_sync_ctrl <= REG_RESET;
            host_data_out  <= REG_RESET;
            host_data_oe   <= 1'b0;
            int_addr       <= '0;
            int_wdata      <= '0;
            int_we         <= 1'b0;
            int_re         <= 1'b0;
        end else begin
            state          <= next_state;
            acc_read       <= next_acc_read;
            acc_addr       <= next_acc_addr;
            acc_data       <= next_acc_data;
            data_low       <= next_data_low;
            data_mid       <= next_data_mid;
            data_high      <= next_data_high;
            chan_addr      <= next_chan_addr;
            addr_ctrl      <= next_addr_ctrl;
            sleep_ctrl     <= next_sleep;
            pin_sync_ctrl  <= next_pin_sync;
            soft_sync_ctrl <= next_soft_sync;
            host_data_out  <= next_dout;
            host_data_oe   <= next_oe;
            int_addr       <= next_int_addr;
            int_wdata      <= next_int_wdata;
            int_we         <= next_int_we;
            int_re         <= next_int_re;
        end
    end

    // Split mode: busy low while working; strobe mode: low once done
    assign transfer_ack_n = mode_s
        ? (state != ST_DONE)
        : !(state == ST_ACCESS || state == ST_WAIT);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_split_busy;
        !mode_s && (state == ST_ACCESS || state == ST_WAIT)
            |-> !transfer_ack_n;
    endproperty
    a_split_busy: assert property (p_split_busy)
        else $error("split mode ready not low during access");

    sequence s_ack_low;
        mode_s && !transfer_ack_n;
    endsequence
    property p_ack_hold;
        s_ack_low ##0 (strobe_on && $stable(mode_s)) |=> !transfer_ack_n;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("ack released while data strobe still active");

    // Ack may only fall once the triggered internal write has gone out
    property p_ack_only_done;
        s_ack_low ##0 ($fell(transfer_ack_n) && $stable(mode_s)
            && !acc_read && acc_addr == EXT_DATA_LOW) |-> int_we;
    endproperty
    a_ack_only_done: assert property (p_ack_only_done)
        else $error("ack low before internal access completed");

    property p_serial_wins;
        ser_done && (state == ST_ACCESS) |=> (state == ST_ACCESS);
    endproperty
    a_serial_wins: assert property (p_serial_wins)
        else $error("parallel access not stalled by serial write");

    property p_trigger;
        int_we |-> $past(wr_go && wr_a == EXT_DATA_LOW);
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("internal write without low byte write");

    property p_autoinc;
        (int_we || int_re) && $past(addr_ctrl[ACR_AUTOINC])
            && !$past(wr_go && wr_a == EXT_CHAN_ADDR)
            |-> chan_addr == $past(chan_addr) + 8'h01;
    endproperty
    a_autoinc: assert property (p_autoinc)
        else $error("channel address not incremented");

    property p_nibble;
        data_high[7:NIBBLE_W] == 4'h0;
    endproperty
    a_nibble: assert property (p_nibble)
        else $error("high nibble register holds upper bits");

    sequence s_read_fetch;
        (state == ST_ACCESS) ##1 (int_re && state == ST_WAIT);
    endsequence
    property p_read_load;
        s_read_fetch |=> data_mid == $past(int_rdata[15:8])
            && host_data_out == $past(int_rdata[7:0]);
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("internal read did not load data bytes");

    property p_serial_write;
        ser_done && ser_addr == EXT_DATA_MID |=> data_mid == $past(ser_data);
    endproperty
    a_serial_write: assert property (p_serial_write)
        else $error("serial write not applied");
endmodule : hcp_port

//--- tb/hcp_host_model.sv
// Host model: drives the parallel port pins and the serial write input.
// Assumes the bench core clock; serial clock stands still between frames.
module hcp_host_model
    import hcp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [7:0]        host_data_out,
    input  wire logic              host_data_oe,
    input  wire logic              transfer_ack_n,
    output logic                   strobe_dir_mode,
    output logic                   cs_n,
    output logic                   rd_ds_n,
    output logic                   wr_rw_n,
    output logic      [EXT_AW-1:0] host_addr,
    output logic      [7:0]        host_data_in,
    output logic                   serial_clk,
    output logic                   serial_ctrl_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        strobe_dir_mode = 1'b1;
        cs_n = 1'b1;
        rd_ds_n = 1'b1;
        wr_rw_n = 1'b1;
        host_addr = '0;
        host_data_in = 8'h00;
        serial_clk = 1'b1;
        serial_ctrl_in = 1'b0;
    end

    // Values are taken at the edge where the handshake is sampled
    task automatic wait_ack(input logic lvl, inout bit ok);
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (transfer_ack_n === lvl) break;
        end
        if (n == 40) ok = 0;
    endtask : wait_ack

    task automatic xfer(input logic md, input logic wr,
                        input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q, output bit ok);
        ok = 1;
        @(posedge clk);
        strobe_dir_mode <= md;
        repeat (3) @(posedge clk);
        cs_n <= 1'b0;
        host_addr <= a;
        host_data_in <= d;
        rd_ds_n <= md ? 1'b0 : wr;
        wr_rw_n <= ~wr;
        wait_ack(1'b0, ok);
        if (!md) wait_ack(1'b1, ok);
        q = host_data_out;
        if (!wr && host_data_oe !== 1'b1) ok = 0;
        cs_n <= 1'b1;
        rd_ds_n <= 1'b1;
        wr_rw_n <= 1'b1;
        // Released bus shows the inverse, never the last value
        host_data_in <= ~d;
        if (md) wait_ack(1'b1, ok);
        repeat (4) @(posedge clk);
    endtask : xfer

    // Clock is supplied here only, data moves after the rising edge
    task automatic ser(input logic [2:0] a, input logic [7:0] d,
                       input logic [3:0] dc);
        logic [16:0] w;
        w = {1'b0, 1'b1, dc, a, d};
        for (int i = 16; i >= 0; i--) begin
            serial_ctrl_in <= w[i];
            #20 serial_clk <= 1'b0;
            #24 serial_clk <= 1'b1;
            #4;
        end
        serial_ctrl_in <= ~w[0];
    endtask : ser
endmodule : hcp_host_model

//--- tb/hcp_port_test.sv
// Self-checking bench for the host control port.
// Assumes the host model beside it; internal register file modelled here.
module hcp_port_test import hcp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              strobe_dir_mode, cs_n, rd_ds_n, wr_rw_n;
    logic              serial_clk, serial_ctrl_in;
    logic [EXT_AW-1:0] host_addr;
    logic [7:0]        host_data_in, host_data_out;
    logic              host_data_oe, transfer_ack_n;
    logic [INT_AW-1:0] int_addr;
    logic [INT_DW-1:0] int_wdata, int_rdata;
    logic              int_we, int_re;
    logic [7:0]        sleep_ctrl, pin_sync_ctrl, soft_sync_ctrl;
    logic [INT_DW-1:0] mem [1024];
    int                failures = 0;
    int                n_tests = 0;
    int                we_cnt = 0;
    int                re_cnt = 0;
    logic [7:0]        q;

    always #2.5 clk = ~clk;

    // Register file: writes land on the edge, reads follow the address,
    // so data stands in the cycle the read pulse does
    always @(posedge clk) begin
        if (int_we) mem[int_addr] <= int_wdata;
        if (int_we) we_cnt <= we_cnt + 1;
        if (int_re) re_cnt <= re_cnt + 1;
    end
    assign int_rdata = mem[int_addr];

    hcp_port u_dut (
        .clk, .reset, .strobe_dir_mode, .cs_n, .rd_ds_n, .wr_rw_n,
        .host_addr, .host_data_in, .host_data_out, .host_data_oe,
        .transfer_ack_n, .serial_clk, .serial_ctrl_in, .int_addr,
        .int_wdata, .int_we, .int_re, .int_rdata, .sleep_ctrl,
        .pin_sync_ctrl, .soft_sync_ctrl
    );

    hcp_host_model u_host (
        .clk, .host_data_out, .host_data_oe, .transfer_ack_n,
        .strobe_dir_mode, .cs_n, .rd_ds_n, .wr_rw_n, .host_addr,
        .host_data_in, .serial_clk, .serial_ctrl_in
    );

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // A handshake that never completes ends the run
    task automatic acc(input logic md, input logic wr, input logic [2:0] a,
                       input logic [7:0] d);
        bit ok;
        u_host.xfer(md, wr, a, d, q, ok);
        check(ok, 1'b1);
        if (!ok) wrap_up();
    endtask : acc

    task automatic t_reset();
        check(transfer_ack_n, 1'b1);
        check(host_data_oe, 1'b0);
        check(sleep_ctrl, REG_RESET);
        check(pin_sync_ctrl, REG_RESET);
        acc(1'b1, 1'b0, EXT_SLEEP, 8'h00);
        check(q, REG_RESET);
    endtask : t_reset

    task automatic t_strobe_write();
        acc(1'b1, 1'b1, EXT_ADDR_CTRL, 8'h02);
        acc(1'b1, 1'b1, EXT_CHAN_ADDR, 8'h87);
        acc(1'b1, 1'b1, EXT_DATA_HIGH, 8'hf5);
        acc(1'b1, 1'b1, EXT_DATA_MID, 8'hcb);
        check(we_cnt, 0);
        acc(1'b1, 1'b1, EXT_DATA_LOW, 8'hef);
        check(we_cnt, 1);
        check(mem[10'h287], 20'h5cbef);
    endtask : t_strobe_write

    task automatic t_strobe_read();
        mem[10'h1f3] = 20'h3a5c6;
        acc(1'b1, 1'b1, EXT_ADDR_CTRL, 8'h01);
        acc(1'b1, 1'b1, EXT_CHAN_ADDR, 8'hf3);
        acc(1'b1, 1'b0, EXT_DATA_LOW, 8'h00);
        check(q, 8'hc6);
        acc(1'b1, 1'b0, EXT_DATA_MID, 8'h00);
        check(q, 8'ha5);
        acc(1'b1, 1'b0, EXT_DATA_HIGH, 8'h00);
        check(q & 8'h0f, 8'h03);
        check(we_cnt, 1);
        check(re_cnt, 1);
        acc(1'b1, 1'b0, EXT_ADDR_CTRL, 8'h00);
        check(q, 8'h01);
    endtask : t_strobe_read

    // Split strobes with auto-increment: two low writes, two locations
    task automatic t_split_autoinc();
        acc(1'b0, 1'b1, EXT_ADDR_CTRL, 8'h80);
        acc(1'b0, 1'b1, EXT_CHAN_ADDR, 8'h10);
        acc(1'b0, 1'b1, EXT_DATA_MID, 8'h12);
        acc(1'b0, 1'b1, EXT_DATA_HIGH, 8'h04);
        acc(1'b0, 1'b1, EXT_DATA_LOW, 8'h34);
        acc(1'b0, 1'b1, EXT_DATA_LOW, 8'h56);
        check(mem[10'h010], 20'h41234);
        check(mem[10'h011], 20'h41256);
        acc(1'b0, 1'b0, EXT_CHAN_ADDR, 8'h00);
        check(q, 8'h12);
        mem[10'h012] = 20'h0009a;
        acc(1'b0, 1'b0, EXT_DATA_LOW, 8'h00);
        check(q, 8'h9a);
    endtask : t_split_autoinc

    // High don't-care and data bits must not restart the frame
    task automatic t_serial();
        u_host.ser(EXT_SLEEP, 8'ha5, 4'hf);
        repeat (10) @(posedge clk);
        check(sleep_ctrl, 8'ha5);
        u_host.ser(EXT_ADDR_CTRL, 8'h03, 4'h0);
        u_host.ser(EXT_CHAN_ADDR, 8'hc4, 4'ha);
        u_host.ser(EXT_DATA_MID, 8'h7e, 4'h0);
        u_host.ser(EXT_DATA_HIGH, 8'h0b, 4'h5);
        u_host.ser(EXT_DATA_LOW, 8'h19, 4'h0);
        repeat (10) @(posedge clk);
        check(mem[10'h3c4], 20'hb7e19);
    endtask : t_serial

    // Parallel write swept cycle by cycle across the serial write landing;
    // odd start offset keeps the delay off the clock edge
    task automatic t_collide();
        for (int k = 0; k < 6; k++) begin
            fork
                u_host.ser(EXT_PIN_SYNC, 8'h30 + 8'(k), 4'h0);
                begin
                    #(757 + 5 * k);
                    acc(1'b1, 1'b1, EXT_SOFT_SYNC, 8'hc0 + 8'(k));
                end
            join
            repeat (10) @(posedge clk);
            check(pin_sync_ctrl, 8'h30 + 8'(k));
            check(soft_sync_ctrl, 8'hc0 + 8'(k));
        end
        acc(1'b1, 1'b0, EXT_PIN_SYNC, 8'h00);
        check(q, 8'h00);
    endtask : t_collide

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_strobe_write();
        t_strobe_read();
        t_split_autoinc();
        t_serial();
        t_collide();
        wrap_up();
    end
endmodule : hcp_port_test
